// >>> src/uis_intr_status.v
// interrupt status registers of the dual-role usb controller, apb slave
//
// Chosen here: register access over APB.
`timescale 1ns/1ns
`include "uis_map.vh"

// Notes on behaviour
// - group flags read-only, clear with enabled causes
// - direct flags cleared by writing one
// - device group flags only in device mode
// - setup flag on completed setup stage
// - setup updates control endpoint stall/nak/toggle/protect
// - set-address goes to auto address, no flag
// - power error on fault pin falling edge
// - line change when lines leave se0
// - host group flags mirror enabled lower causes
// - ram read-back ready sets its flag
// - free-running counter overflow wraps and flags
// - dma stop or termination sets done
// - drive register access done sets flag
// - drive status bit layout, bit three reserved
// - interrupt low while a summary bit enabled in the summary mask is set
module uis_intr_status #(
    parameter CNT_W = 32
) (
    input wire CLK,
    input wire RST,
    input wire CE,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire DEV_MODE,
    input wire [31:0] DEV_GRP_STAT,
    input wire [31:0] DEV_GRP_ENB,
    input wire [47:0] HOST_GRP_STAT,
    input wire [47:0] HOST_GRP_ENB,
    input wire SETUP_DONE,
    input wire SETUP_IS_SET_ADDR,
    input wire POWER_SWITCH_FAULT_PIN,
    input wire HOST_DP,
    input wire HOST_DM,
    input wire RAM_READBACK_READY,
    input wire [1:0] DMA_BEAT,
    input wire [1:0] DMA_CLEAR,
    input wire [1:0] DMA_FREE_RUN,
    input wire [1:0] DMA_STOPPED,
    input wire [1:0] DMA_TERM_DONE,
    input wire [7:0] DRIVE_EVENT,
    output reg IRQ_OUT_N,
    output reg AUTO_ADDR_REQ,
    output reg EP0_FORCED_STALL_CLR,
    output reg EP0_FORCED_NAK_SET,
    output reg EP0_TOGGLE_STATE_SET,
    output reg CTRL_EP_PROTECT_SET
);
    // =================================================================
    // helpers
    function any_enabled;
        input [7:0] stat;
        input [7:0] enb;
        begin
            any_enabled = |(stat & enb);
        end
    endfunction

    function [7:0] w1c_next;
        input [7:0] cur;
        input [7:0] clr;
        input [7:0] set;
        begin
            w1c_next = (cur & ~clr) | set;
        end
    endfunction

    // =================================================================
    // state
    reg [7:0] dev_stat_ff;
    reg [7:0] host_stat_ff;
    reg [7:0] cpu_stat_ff;
    reg [7:0] ide_stat_ff;
    reg [7:0] dev_enb_ff;
    reg [7:0] host_enb_ff;
    reg [7:0] cpu_enb_ff;
    reg [7:0] ide_enb_ff;
    reg [7:0] sum_ff;
    reg [7:0] sum_mask_ff;
    reg pf_s1_ff;
    reg pf_s2_ff;
    reg pf_prev_ff;
    reg [1:0] ln_s1_ff;
    reg [1:0] ln_s2_ff;
    reg se0_prev_ff;
    reg [7:0] nxt_dev_stat;
    reg [7:0] nxt_host_stat;
    reg [7:0] nxt_cpu_stat;
    reg [7:0] nxt_ide_stat;
    reg [7:0] nxt_sum;
    reg [31:0] nxt_rdata;
    reg nxt_err;
    reg [7:0] host_grp;
    reg [7:0] dev_set;
    reg [7:0] host_set;
    reg [7:0] cpu_set;
    reg [7:0] ide_set;
    integer i;

    wire [CNT_W-1:0] dma0_count;
    wire [CNT_W-1:0] dma1_count;
    wire dma0_wrap;
    wire dma1_wrap;

    // =================================================================
    // dma transfer counters
    uis_dma_counter #(.W(CNT_W)) u_dma0 (
        .clk(CLK),
        .rst(RST),
        .ce(CE),
        .clear(DMA_CLEAR[0]),
        .beat(DMA_BEAT[0]),
        .free_run(DMA_FREE_RUN[0]),
        .count_ff(dma0_count),
        .wrap_ff(dma0_wrap)
    );

    uis_dma_counter #(.W(CNT_W)) u_dma1 (
        .clk(CLK),
        .rst(RST),
        .ce(CE),
        .clear(DMA_CLEAR[1]),
        .beat(DMA_BEAT[1]),
        .free_run(DMA_FREE_RUN[1]),
        .count_ff(dma1_count),
        .wrap_ff(dma1_wrap)
    );

    // =================================================================
    // apb decode
    wire [5:0] idx = PADDR[7:2];
    wire access = PSEL & PENABLE;
    wire done = access & PREADY;
    wire wr_done = done & PWRITE & ~PSLVERR;
    wire rd_done = done & ~PWRITE & ~PSLVERR;
    wire [7:0] wbyte = PWDATA[7:0];

    // =================================================================
    // pin synchronisers and edge detection
    wire se0 = ~ln_s2_ff[1] & ~ln_s2_ff[0];
    wire pwr_fall = pf_prev_ff & ~pf_s2_ff;
    wire line_left_se0 = se0_prev_ff & ~se0;

    // =================================================================
    // group flags mirror enabled lower causes, no storage of their own
    wire dev_bulk_group_flag = DEV_MODE & any_enabled(DEV_GRP_STAT[31:24],
        DEV_GRP_ENB[31:24]);
    wire dev_fifo_group_flag = DEV_MODE & any_enabled(DEV_GRP_STAT[23:16],
        DEV_GRP_ENB[23:16]);
    wire dev_ctrl_ep_group_flag = DEV_MODE & any_enabled(DEV_GRP_STAT[15:8],
        DEV_GRP_ENB[15:8]);
    wire dev_other_ep_group_flag = DEV_MODE & any_enabled(DEV_GRP_STAT[7:0],
        DEV_GRP_ENB[7:0]);

    always @* begin
        host_grp = 8'h00;
        for (i = 0; i < `UIS_HOST_NGRP; i = i + 1) begin
            host_grp[i] = any_enabled(HOST_GRP_STAT[i*8 +: 8],
                HOST_GRP_ENB[i*8 +: 8]);
        end
    end

    wire setup_evt = SETUP_DONE & DEV_MODE & ~SETUP_IS_SET_ADDR;
    wire addr_evt = SETUP_DONE & DEV_MODE & SETUP_IS_SET_ADDR;

    wire [7:0] dev_view = {3'b000, dev_bulk_group_flag, dev_stat_ff[`UIS_DEV_SETUP],
        dev_fifo_group_flag, dev_ctrl_ep_group_flag, dev_other_ep_group_flag};
    wire [7:0] host_view = {host_stat_ff[7:6], host_grp[5:0]};

    // =================================================================
    // hardware set terms
    always @* begin
        dev_set = 8'h00;
        host_set = 8'h00;
        cpu_set = 8'h00;
        ide_set = 8'h00;
        dev_set[`UIS_DEV_SETUP] = setup_evt;
        host_set[`UIS_HOST_PWR_ERR] = pwr_fall;
        host_set[`UIS_HOST_LINE_CHG] = line_left_se0;
        cpu_set[`UIS_CPU_RAM_DONE] = RAM_READBACK_READY;
        cpu_set[`UIS_CPU_CH0_WRAP] = dma0_wrap;
        cpu_set[`UIS_CPU_CH1_WRAP] = dma1_wrap;
        cpu_set[`UIS_CPU_CH0_DONE] = DMA_STOPPED[0] | DMA_TERM_DONE[0];
        cpu_set[`UIS_CPU_CH1_DONE] = DMA_STOPPED[1] | DMA_TERM_DONE[1];
        // bit three of the drive status is reserved and never set
        ide_set = DRIVE_EVENT & `UIS_IDE_W1C;
    end

    // =================================================================
    // next status: write-one clears only direct bits, a set wins
    always @* begin
        nxt_dev_stat = w1c_next(dev_stat_ff,
            (wr_done && idx == `UIS_IDX_DEV) ? (wbyte & `UIS_DEV_W1C) : 8'h00,
            dev_set);
        nxt_host_stat = w1c_next(host_stat_ff,
            (wr_done && idx == `UIS_IDX_HOST) ? (wbyte & `UIS_HOST_W1C) : 8'h00,
            host_set);
        nxt_cpu_stat = w1c_next(cpu_stat_ff,
            (wr_done && idx == `UIS_IDX_CPU) ? (wbyte & `UIS_CPU_W1C) : 8'h00,
            cpu_set);
        nxt_ide_stat = w1c_next(ide_stat_ff,
            (wr_done && idx == `UIS_IDX_IDE) ? (wbyte & `UIS_IDE_W1C) : 8'h00,
            ide_set);
    end

    // =================================================================
    // summary: sticky, cleared by reading, re-set while a cause stays
    wire dev_any = any_enabled(dev_view, dev_enb_ff);
    wire host_any = any_enabled(host_view, host_enb_ff);
    wire cpu_any = any_enabled(cpu_stat_ff, cpu_enb_ff);
    wire ide_any = any_enabled(ide_stat_ff, ide_enb_ff);

    always @* begin
        nxt_sum = (rd_done && idx == `UIS_IDX_SUM) ? 8'h00 : sum_ff;
        nxt_sum = nxt_sum | {dev_any, host_any, cpu_any, ide_any, 4'h0};
    end

    // =================================================================
    // read mux and unmapped detection
    always @* begin
        nxt_rdata = 32'h0000_0000;
        nxt_err = 1'b0;
        if (PADDR[1:0] != 2'b00) begin
            nxt_err = 1'b1;
        end else begin
            case (idx)
                `UIS_IDX_SUM: nxt_rdata[7:0] = sum_ff;
                `UIS_IDX_DEV: nxt_rdata[7:0] = dev_view;
                `UIS_IDX_HOST: nxt_rdata[7:0] = host_view;
                `UIS_IDX_CPU: nxt_rdata[7:0] = cpu_stat_ff;
                `UIS_IDX_IDE: nxt_rdata[7:0] = ide_stat_ff;
                `UIS_IDX_SUM_MASK: nxt_rdata[7:0] = sum_mask_ff;
                `UIS_IDX_DEV_ENB: nxt_rdata[7:0] = dev_enb_ff;
                `UIS_IDX_HOST_ENB: nxt_rdata[7:0] = host_enb_ff;
                `UIS_IDX_CPU_ENB: nxt_rdata[7:0] = cpu_enb_ff;
                `UIS_IDX_IDE_ENB: nxt_rdata[7:0] = ide_enb_ff;
                `UIS_IDX_DMA0_CNT: nxt_rdata[CNT_W-1:0] = dma0_count;
                `UIS_IDX_DMA1_CNT: nxt_rdata[CNT_W-1:0] = dma1_count;
                default: nxt_err = 1'b1;
            endcase
        end
    end

    // =================================================================
    // apb handshake: one wait state, data and error settle with ready
    always @(posedge CLK) begin
        if (RST) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else if (CE) begin
            PREADY <= access & ~PREADY;
            if (access & ~PREADY) begin
                PRDATA <= PWRITE ? 32'h0000_0000 : nxt_rdata;
                PSLVERR <= nxt_err;
            end else begin
                PRDATA <= 32'h0000_0000;
                PSLVERR <= 1'b0;
            end
        end
    end

    // =================================================================
    // software-written enables and mask
    always @(posedge CLK) begin
        if (RST) begin
            dev_enb_ff <= `UIS_ENB_RST;
            host_enb_ff <= `UIS_ENB_RST;
            cpu_enb_ff <= `UIS_ENB_RST;
            ide_enb_ff <= `UIS_ENB_RST;
            sum_mask_ff <= `UIS_ENB_RST;
        end else if (CE && wr_done) begin
            case (idx)
                `UIS_IDX_DEV_ENB: dev_enb_ff <= wbyte;
                `UIS_IDX_HOST_ENB: host_enb_ff <= wbyte;
                `UIS_IDX_CPU_ENB: cpu_enb_ff <= wbyte;
                `UIS_IDX_IDE_ENB: ide_enb_ff <= wbyte;
                `UIS_IDX_SUM_MASK: sum_mask_ff <= wbyte;
                default: sum_mask_ff <= sum_mask_ff;
            endcase
        end
    end

    // =================================================================
    // synchronisers; the power-error path must never be gated by mode
    always @(posedge CLK) begin
        if (RST) begin
            pf_s1_ff <= 1'b1;
            pf_s2_ff <= 1'b1;
            pf_prev_ff <= 1'b1;
            ln_s1_ff <= 2'b00;
            ln_s2_ff <= 2'b00;
            se0_prev_ff <= 1'b1;
        end else if (CE) begin
            pf_s1_ff <= POWER_SWITCH_FAULT_PIN;
            pf_s2_ff <= pf_s1_ff;
            pf_prev_ff <= pf_s2_ff;
            ln_s1_ff <= {HOST_DP, HOST_DM};
            ln_s2_ff <= ln_s1_ff;
            se0_prev_ff <= se0;
        end
    end

    // =================================================================
    // status registers and outputs
    always @(posedge CLK) begin
        if (RST) begin
            dev_stat_ff <= `UIS_STAT_RST;
            host_stat_ff <= `UIS_STAT_RST;
            cpu_stat_ff <= `UIS_STAT_RST;
            ide_stat_ff <= `UIS_STAT_RST;
            sum_ff <= `UIS_STAT_RST;
            IRQ_OUT_N <= 1'b1;
            AUTO_ADDR_REQ <= 1'b0;
            EP0_FORCED_STALL_CLR <= 1'b0;
            EP0_FORCED_NAK_SET <= 1'b0;
            EP0_TOGGLE_STATE_SET <= 1'b0;
            CTRL_EP_PROTECT_SET <= 1'b0;
        end else if (CE) begin
            dev_stat_ff <= nxt_dev_stat;
            host_stat_ff <= nxt_host_stat;
            cpu_stat_ff <= nxt_cpu_stat;
            ide_stat_ff <= nxt_ide_stat;
            sum_ff <= nxt_sum;
            // follows the next summary so a read that empties it releases the line high
            IRQ_OUT_N <= ~|(nxt_sum & sum_mask_ff);
            AUTO_ADDR_REQ <= addr_evt;
            EP0_FORCED_STALL_CLR <= setup_evt;
            EP0_FORCED_NAK_SET <= setup_evt;
            EP0_TOGGLE_STATE_SET <= setup_evt;
            CTRL_EP_PROTECT_SET <= setup_evt;
        end
    end
endmodule

// >>> src/uis_map.vh
// register map, bit positions and reset values of the interrupt status block
`ifndef UIS_MAP_VH
`define UIS_MAP_VH

// =====================================================================
// register indexes (byte address is four times the index)
`define UIS_IDX_SUM 6'h00
`define UIS_IDX_DEV 6'h01
`define UIS_IDX_HOST 6'h02
`define UIS_IDX_CPU 6'h03
`define UIS_IDX_IDE 6'h04
`define UIS_IDX_SUM_MASK 6'h10
`define UIS_IDX_DEV_ENB 6'h11
`define UIS_IDX_HOST_ENB 6'h12
`define UIS_IDX_CPU_ENB 6'h13
`define UIS_IDX_IDE_ENB 6'h14
`define UIS_IDX_DMA0_CNT 6'h20
`define UIS_IDX_DMA1_CNT 6'h21

// =====================================================================
// summary register bits
`define UIS_SUM_DEV 7
`define UIS_SUM_HOST 6
`define UIS_SUM_CPU 5
`define UIS_SUM_IDE 4

// =====================================================================
// device event status bits
`define UIS_DEV_BULK 4
`define UIS_DEV_SETUP 3
`define UIS_DEV_FIFO 2
`define UIS_DEV_CEP 1
`define UIS_DEV_OEP 0

// =====================================================================
// host event status bits (5..0 are group flags, slice n of the inputs)
`define UIS_HOST_PWR_ERR 7
`define UIS_HOST_LINE_CHG 6
`define UIS_HOST_NGRP 6

// =====================================================================
// cpu port event status bits
`define UIS_CPU_RAM_DONE 7
`define UIS_CPU_CH1_WRAP 3
`define UIS_CPU_CH1_DONE 2
`define UIS_CPU_CH0_WRAP 1
`define UIS_CPU_CH0_DONE 0

// =====================================================================
// drive event status bits
`define UIS_IDE_REG_DONE 7
`define UIS_IDE_REG_ERR 6
`define UIS_IDE_SEQ_DONE 5
`define UIS_IDE_AUTO_DONE 4
`define UIS_IDE_DMA_DONE 2
`define UIS_IDE_IRQ_SEEN 1
`define UIS_IDE_TERM_SEEN 0

// =====================================================================
// write-1-to-clear masks and reset values
`define UIS_DEV_W1C 8'h08
`define UIS_HOST_W1C 8'hc0
`define UIS_CPU_W1C 8'h8f
`define UIS_IDE_W1C 8'hf7
`define UIS_STAT_RST 8'h00
`define UIS_ENB_RST 8'h00
`define UIS_CNT_RST 32'h0000_0000

`endif

// >>> src/uis_dma_counter.v
// transfer counter of one dma channel with free-running wrap
`timescale 1ns/1ns
module uis_dma_counter #(
    parameter W = 32
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire clear,
    input wire beat,
    input wire free_run,
    output reg [W-1:0] count_ff,
    output reg wrap_ff
);
    // =================================================================
    // counter
    always @(posedge clk) begin
        if (rst) begin
            count_ff <= {W{1'b0}};
            wrap_ff <= 1'b0;
        end else if (ce) begin
            wrap_ff <= 1'b0;
            if (clear) begin
                count_ff <= {W{1'b0}};
            end else if (beat) begin
                if (&count_ff) begin
                    // outside free-running mode the count stops at the top
                    if (free_run) begin
                        count_ff <= {W{1'b0}};
                        wrap_ff <= 1'b1;
                    end
                end else begin
                    count_ff <= count_ff + 1'b1;
                end
            end
        end
    end
endmodule

// >>> tb/uis_intr_status_sva.sv
// assertion checker for the interrupt status block
`timescale 1ns/1ns
module uis_intr_status_sva (
    input wire CLK,
    input wire RST,
    input wire PSEL,
    input wire PENABLE,
    input wire [7:0] PADDR,
    input wire [31:0] PRDATA,
    input wire PREADY,
    input wire PSLVERR,
    input wire DEV_MODE,
    input wire SETUP_DONE,
    input wire SETUP_IS_SET_ADDR,
    input wire AUTO_ADDR_REQ,
    input wire EP0_FORCED_STALL_CLR,
    input wire EP0_FORCED_NAK_SET,
    input wire EP0_TOGGLE_STATE_SET,
    input wire CTRL_EP_PROTECT_SET
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // =========================================
    // helpers
    wire [5:0] idx = PADDR[7:2];
    wire mapped = PADDR[1:0] == 2'h0 && (idx <= 6'h04 || (idx >= 6'h10 && idx <= 6'h14)
        || idx == 6'h20 || idx == 6'h21);
    wire ep0_all = EP0_FORCED_STALL_CLR && EP0_FORCED_NAK_SET && EP0_TOGGLE_STATE_SET
        && CTRL_EP_PROTECT_SET;
    sequence s_access;
        PSEL && PENABLE && !PREADY;
    endsequence
    sequence s_setup_std;
        SETUP_DONE && DEV_MODE && !SETUP_IS_SET_ADDR;
    endsequence
    // =========================================
    // properties
    property p_one_wait;
        s_access |=> PREADY;
    endproperty
    property p_ready_pulse;
        PREADY |=> !PREADY;
    endproperty
    property p_refuse;
        s_access ##0 !mapped |=> PREADY && PSLVERR && PRDATA == 32'h0;
    endproperty
    property p_accept;
        s_access ##0 mapped |=> PREADY && !PSLVERR;
    endproperty
    property p_quiet;
        !PREADY |-> PRDATA == 32'h0 && !PSLVERR;
    endproperty
    property p_setup;
        s_setup_std |=> ep0_all && !AUTO_ADDR_REQ;
    endproperty
    property p_set_addr;
        SETUP_DONE && DEV_MODE && SETUP_IS_SET_ADDR |=> AUTO_ADDR_REQ && !CTRL_EP_PROTECT_SET;
    endproperty
    property p_no_ep0;
        !(SETUP_DONE && DEV_MODE) |=> !CTRL_EP_PROTECT_SET && !AUTO_ADDR_REQ;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("late ready");
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
    a_refuse: assert property (p_refuse) else $error("bad address accepted");
    a_accept: assert property (p_accept) else $error("good address refused");
    a_quiet: assert property (p_quiet) else $error("data outside ready");
    a_setup: assert property (p_setup) else $error("setup pulses missing");
    a_set_addr: assert property (p_set_addr) else $error("set address wrong");
    a_no_ep0: assert property (p_no_ep0) else $error("stray setup pulse");
endmodule

bind uis_intr_status uis_intr_status_sva u_sva (
    .CLK(CLK),
    .RST(RST),
    .PSEL(PSEL),
    .PENABLE(PENABLE),
    .PADDR(PADDR),
    .PRDATA(PRDATA),
    .PREADY(PREADY),
    .PSLVERR(PSLVERR),
    .DEV_MODE(DEV_MODE),
    .SETUP_DONE(SETUP_DONE),
    .SETUP_IS_SET_ADDR(SETUP_IS_SET_ADDR),
    .AUTO_ADDR_REQ(AUTO_ADDR_REQ),
    .EP0_FORCED_STALL_CLR(EP0_FORCED_STALL_CLR),
    .EP0_FORCED_NAK_SET(EP0_FORCED_NAK_SET),
    .EP0_TOGGLE_STATE_SET(EP0_TOGGLE_STATE_SET),
    .CTRL_EP_PROTECT_SET(CTRL_EP_PROTECT_SET)
);

// >>> tb/uis_apb_host.sv
// apb host model that reads and clears the interrupt status registers
`timescale 1ns/1ns
module uis_apb_host (
    input wire clk,
    output reg psel,
    output reg penable,
    output reg pwrite,
    output reg [7:0] paddr,
    output reg [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = 43'h0;
    end
    // =========================================
    // one transfer, held until pready is sampled high
    task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q, output e);
        begin
            @(posedge clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            @(posedge clk);
            while (!pready) @(posedge clk);
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            // released lines must not look like a held request
            paddr <= ~a;
            pwdata <= ~d;
        end
    endtask
endmodule

// >>> tb/uis_intr_status_tb_top.sv
// self-checking bench for the interrupt status block
`timescale 1ns/1ns
module uis_intr_status_tb_top;
    reg clk;
    reg rst, dev_mode, setup_done, set_addr, fault_pin, host_dp, ram_ready;
    reg [31:0] dev_stat, dev_enb;
    reg [47:0] host_stat, host_enb;
    reg [1:0] dma_beat, dma_free_run, dma_stopped, dma_term;
    reg [7:0] drive_event;
    reg [7:0] a;
    integer num_checks, fail_count;
    wire psel, penable, pwrite, pready, pslverr, irq_n;
    wire [7:0] paddr;
    wire [31:0] pwdata, prdata;

    uis_apb_host u_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // short counter width so that a free-running wrap is reachable
    uis_intr_status #(.CNT_W(4)) DUT (.CLK(clk), .RST(rst), .CE(1'b1), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .DEV_MODE(dev_mode), .DEV_GRP_STAT(dev_stat),
        .DEV_GRP_ENB(dev_enb), .HOST_GRP_STAT(host_stat), .HOST_GRP_ENB(host_enb),
        .SETUP_DONE(setup_done), .SETUP_IS_SET_ADDR(set_addr),
        .POWER_SWITCH_FAULT_PIN(fault_pin), .HOST_DP(host_dp), .HOST_DM(1'b0),
        .RAM_READBACK_READY(ram_ready), .DMA_BEAT(dma_beat), .DMA_CLEAR(2'b00),
        .DMA_FREE_RUN(dma_free_run), .DMA_STOPPED(dma_stopped), .DMA_TERM_DONE(dma_term),
        .DRIVE_EVENT(drive_event), .IRQ_OUT_N(irq_n), .AUTO_ADDR_REQ(),
        .EP0_FORCED_STALL_CLR(), .EP0_FORCED_NAK_SET(), .EP0_TOGGLE_STATE_SET(),
        .CTRL_EP_PROTECT_SET());

    // =========================================
    // helpers
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", num_checks, fail_count);
            if (fail_count == 0 && num_checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task chk(input [32:0] got, input [32:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task rd(input [7:0] ad, input [31:0] exp, input ee);
        reg [31:0] q;
        reg e;
        begin
            u_host.xfer(1'b0, ad, 32'h0, q, e);
            chk({e, q}, {ee, exp});
        end
    endtask
    task wr(input [7:0] ad, input [7:0] d);
        reg [31:0] q;
        reg e;
        begin
            u_host.xfer(1'b1, ad, {24'h0, d}, q, e);
            chk({32'h0, e}, 33'h0);
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        fail_count = fail_count + 1;
        stop_test;
    end
    // =========================================
    // main sequence
    initial begin
        {dev_mode, setup_done, set_addr, host_dp, ram_ready, dev_stat, dev_enb} = 69'h0;
        {host_stat, host_enb, dma_beat, dma_free_run, dma_stopped, dma_term} = 104'h0;
        drive_event = 8'h00;
        fault_pin = 1'b1;
        rst = 1'b1;
        num_checks = 0;
        fail_count = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (a = 8'h00; a <= 8'h10; a = a + 8'h04) rd(a, 32'h0, 1'b0);
        rd(8'h50, 32'h0, 1'b0);
        rd(8'h14, 32'h0, 1'b1);
        rd(8'h09, 32'h0, 1'b1);
        @(posedge clk) drive_event <= 8'hff;
        @(posedge clk) drive_event <= 8'h00;
        rd(8'h10, 32'hf7, 1'b0);
        wr(8'h10, 8'h00);
        rd(8'h10, 32'hf7, 1'b0);
        wr(8'h10, 8'h0f);
        rd(8'h10, 32'hf0, 1'b0);
        wr(8'h10, 8'hff);
        fork
            wr(8'h10, 8'h80);
            begin
                repeat (3) @(posedge clk);
                drive_event <= 8'h80;
                @(posedge clk) drive_event <= 8'h00;
            end
        join
        rd(8'h10, 32'h80, 1'b0);
        @(posedge clk);
        ram_ready <= 1'b1;
        dma_stopped <= 2'b01;
        dma_term <= 2'b10;
        dma_free_run <= 2'b01;
        @(posedge clk);
        {ram_ready, dma_stopped, dma_term} <= 5'h0;
        rd(8'h0c, 32'h85, 1'b0);
        wr(8'h0c, 8'hff);
        @(posedge clk) dma_beat <= 2'b11;
        repeat (16) @(posedge clk);
        dma_beat <= 2'b00;
        rd(8'h0c, 32'h02, 1'b0);
        rd(8'h80, 32'h0, 1'b0);
        rd(8'h84, 32'hf, 1'b0);
        @(posedge clk) fault_pin <= 1'b0;
        repeat (5) @(posedge clk);
        rd(8'h08, 32'h80, 1'b0);
        @(posedge clk);
        host_dp <= 1'b1; // line change enable is never written while hosting
        host_stat <= 48'h0000_0020_1000;
        host_enb <= 48'h0000_0000_10ff;
        repeat (5) @(posedge clk);
        rd(8'h08, 32'hc2, 1'b0);
        wr(8'h08, 8'hff);
        rd(8'h08, 32'h02, 1'b0);
        @(posedge clk) host_stat <= 48'h0;
        rd(8'h08, 32'h00, 1'b0);
        @(posedge clk);
        dev_mode <= 1'b1;
        dev_stat <= 32'h0102_0400;
        dev_enb <= 32'h0102_04ff;
        rd(8'h04, 32'h16, 1'b0);
        @(posedge clk) setup_done <= 1'b1;
        @(posedge clk) setup_done <= 1'b0;
        rd(8'h04, 32'h1e, 1'b0);
        wr(8'h04, 8'h08);
        rd(8'h04, 32'h16, 1'b0);
        @(posedge clk);
        setup_done <= 1'b1;
        set_addr <= 1'b1;
        @(posedge clk) setup_done <= 1'b0;
        rd(8'h04, 32'h16, 1'b0);
        @(posedge clk) dev_mode <= 1'b0;
        rd(8'h04, 32'h00, 1'b0);
        wr(8'h50, 8'h80);
        rd(8'h50, 32'h80, 1'b0);
        repeat (3) @(posedge clk);
        chk({32'h0, irq_n}, 33'h1);
        wr(8'h40, 8'h10);
        repeat (3) @(posedge clk);
        chk({32'h0, irq_n}, 33'h0);
        wr(8'h10, 8'h80);
        rd(8'h00, 32'h10, 1'b0);
        repeat (3) @(posedge clk);
        chk({32'h0, irq_n}, 33'h1);
        // channel 0 wrap flag still stands; enabling it lights summary bit 5 only
        wr(8'h4c, 8'h02);
        rd(8'h4c, 32'h02, 1'b0);
        rd(8'h00, 32'h20, 1'b0);
        chk({32'h0, irq_n}, 33'h1);
        wr(8'h0c, 8'h02);
        rd(8'h00, 32'h20, 1'b0);
        rd(8'h00, 32'h00, 1'b0);
        stop_test;
    end
endmodule
